// [include/icm_pkg.sv]
/*
  Shared constants and types of the infrared carrier modulator:
  register indices, field positions, reset values and the carrier pair.
  Assumes an 8-bit register port with a 4-bit index.
*/
`default_nettype none

package icm_pkg;

  // ==========================================================
  // Register indices
  typedef logic [3:0] icm_addr_t;
  localparam icm_addr_t ADDR_PRI_HI = 4'h0;
  localparam icm_addr_t ADDR_PRI_LO = 4'h1;
  localparam icm_addr_t ADDR_SEC_HI = 4'h2;
  localparam icm_addr_t ADDR_SEC_LO = 4'h3;
  localparam icm_addr_t ADDR_OUT_CTL = 4'h4;
  localparam icm_addr_t ADDR_MSC = 4'h5;
  localparam icm_addr_t ADDR_MARK_HI = 4'h6;
  localparam icm_addr_t ADDR_MARK_LO = 4'h7;
  localparam icm_addr_t ADDR_SPACE_HI = 4'h8;
  localparam icm_addr_t ADDR_SPACE_LO = 4'h9;

  // ==========================================================
  // Field positions
  localparam int MSC_EN_BIT = 0;
  localparam int MSC_DC_LEVEL_SELECT_BIT = 1;
  localparam int MSC_FSK_BIT = 2;
  localparam int MSC_EXTENDED_SPACE_BIT = 3;
  localparam int MSC_EOCIE_BIT = 4;
  localparam int MSC_END_OF_CYCLE_FLAG_BIT = 7;
  localparam int OUT_LATCH_BIT = 0;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] CARRIER_CNT_RST = 8'h01;
  localparam logic [15:0] MOD_VAL_RST = 16'h0000;
  localparam logic [7:0] CNT_RESTART = 8'h01;
  localparam int TICK_DIV = 8;
  localparam logic [2:0] PRESCALE_LAST = 3'(TICK_DIV - 1);

  // ==========================================================
  // Types
  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} icm_state_e;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } icm_pair_s;

endpackage

`default_nettype wire

// [rtl/icm_carrier.sv]
/*
  Carrier generator: an 8-bit up counter that times the high and low
  phases from a primary or secondary count pair.
  Assumes counts are non-zero and that run is held while carrier is used.
*/
`timescale 1ns/100ps
`default_nettype none

module icm_carrier
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic use_sec,
  input wire icm_pkg::icm_pair_s pri,
  input wire icm_pkg::icm_pair_s sec,
  output logic carrier_q,
  output logic period_end_q
);
  import icm_pkg::*;

  logic [7:0] cnt_q;
  logic sec_q;
  icm_pair_s pair_w;
  logic [7:0] limit_w;
  logic match_w;

  // ==========================================================
  // Compare against the register of the phase in progress
  assign pair_w = sec_q ? sec : pri;
  assign limit_w = carrier_q ? pair_w.hi : pair_w.lo;
  assign match_w = (cnt_q == limit_w);

  // ==========================================================
  // Phase counter; pair swaps only at a period boundary, so no glitch
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= CNT_RESTART;
      carrier_q <= 1'b1;
      sec_q <= 1'b0;
      period_end_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= CNT_RESTART;
      carrier_q <= 1'b1;
      sec_q <= use_sec;
      period_end_q <= 1'b0;
    end
    else if (match_w)
    begin
      cnt_q <= CNT_RESTART;
      carrier_q <= ~carrier_q;
      period_end_q <= ~carrier_q;
      if (!carrier_q)
        sec_q <= use_sec;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
      period_end_q <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_count_restart: assert property (@(posedge clk) disable iff (sys_rst)
    run && match_w |=> cnt_q == CNT_RESTART)
    else $error("carrier counter did not restart at one");
  a_phase_swap: assert property (@(posedge clk) disable iff (sys_rst)
    run && match_w |=> carrier_q != $past(carrier_q))
    else $error("carrier phase did not switch on match");

endmodule // icm_carrier

`default_nettype wire

// [rtl/icm_top.sv]
/*
  Infrared carrier modulator: register port, modulator down counter,
  space comparison, mode control and output pin stage.
  Assumes a single 40 MHz clock and a master that never waits.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module icm_top
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire icm_pkg::icm_addr_t bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_q,
  output logic eoc_irq_q,
  output logic infrared_output_pin_q
);
  import icm_pkg::*;

  // ==========================================================
  // Declarations
  icm_pair_s pri_q;
  icm_pair_s sec_q;
  logic module_enable_q;
  logic dc_level_select_q;
  logic fsk_q;
  logic extended_space_q;
  logic eocie_q;
  logic latch_q;
  logic [15:0] mark_q;
  logic [15:0] space_q;
  logic [16:0] cnt_q;
  logic [15:0] spc_q;
  logic exsp_q;
  logic sec_sel_q;
  logic [2:0] div_q;
  logic end_of_cycle_flag_q;
  logic armed_q;
  icm_state_e state_q;

  logic running_w;
  logic fsk_mode_w;
  logic car_w;
  logic car_end_w;
  logic tick_w;
  logic [16:0] next_cnt_w;
  logic space_hit_w;
  logic reload_w;
  logic start_w;
  logic load_w;
  logic stop_w;
  logic sec_next_w;
  logic gate_w;
  logic mod_w;
  logic pin_d;
  logic clr_w;
  logic end_of_cycle_flag_d;
  logic [7:0] msc_w;
  logic [7:0] rd_mux_w;
  logic wr_pri_hi_w;
  logic wr_pri_lo_w;
  logic wr_sec_hi_w;
  logic wr_sec_lo_w;
  logic wr_out_w;
  logic wr_msc_w;
  logic wr_mark_hi_w;
  logic wr_mark_lo_w;
  logic wr_space_hi_w;
  logic wr_space_lo_w;

  // ==========================================================
  // Write decode
  assign wr_pri_hi_w = bus_wr && (bus_addr == ADDR_PRI_HI);
  assign wr_pri_lo_w = bus_wr && (bus_addr == ADDR_PRI_LO);
  assign wr_sec_hi_w = bus_wr && (bus_addr == ADDR_SEC_HI);
  assign wr_sec_lo_w = bus_wr && (bus_addr == ADDR_SEC_LO);
  assign wr_out_w = bus_wr && (bus_addr == ADDR_OUT_CTL);
  assign wr_msc_w = bus_wr && (bus_addr == ADDR_MSC);
  assign wr_mark_hi_w = bus_wr && (bus_addr == ADDR_MARK_HI);
  assign wr_mark_lo_w = bus_wr && (bus_addr == ADDR_MARK_LO);
  assign wr_space_hi_w = bus_wr && (bus_addr == ADDR_SPACE_HI);
  assign wr_space_lo_w = bus_wr && (bus_addr == ADDR_SPACE_LO);

  // ==========================================================
  // Carrier count pairs; zero counts are the writer's fault
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pri_q <= '{hi: CARRIER_CNT_RST, lo: CARRIER_CNT_RST};
      sec_q <= '{hi: CARRIER_CNT_RST, lo: CARRIER_CNT_RST};
    end
    else
    begin
      if (wr_pri_hi_w) pri_q.hi <= bus_wdata;
      if (wr_pri_lo_w) pri_q.lo <= bus_wdata;
      if (wr_sec_hi_w) sec_q.hi <= bus_wdata;
      if (wr_sec_lo_w) sec_q.lo <= bus_wdata;
    end
  end

  // ==========================================================
  // Mode and control bits; mode bits other than extended space are not double buffered
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      module_enable_q <= 1'b0;
      dc_level_select_q <= 1'b0;
      fsk_q <= 1'b0;
      extended_space_q <= 1'b0;
      eocie_q <= 1'b0;
      latch_q <= 1'b0;
    end
    else
    begin
      if (wr_msc_w)
      begin
        module_enable_q <= bus_wdata[MSC_EN_BIT];
        dc_level_select_q <= bus_wdata[MSC_DC_LEVEL_SELECT_BIT];
        fsk_q <= bus_wdata[MSC_FSK_BIT];
        extended_space_q <= bus_wdata[MSC_EXTENDED_SPACE_BIT];
        eocie_q <= bus_wdata[MSC_EOCIE_BIT];
      end
      if (wr_out_w)
        latch_q <= bus_wdata[OUT_LATCH_BIT];
    end
  end

  // ==========================================================
  // Mark and space buffers, taken at each period load
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mark_q <= MOD_VAL_RST;
      space_q <= MOD_VAL_RST;
    end
    else
    begin
      if (wr_mark_hi_w) mark_q[15:8] <= bus_wdata;
      if (wr_mark_lo_w) mark_q[7:0] <= bus_wdata;
      if (wr_space_hi_w) space_q[15:8] <= bus_wdata;
      if (wr_space_lo_w) space_q[7:0] <= bus_wdata;
    end
  end

  // ==========================================================
  // Carrier generator
  assign running_w = (state_q == ST_RUN);
  assign fsk_mode_w = fsk_q && !dc_level_select_q;

  icm_carrier u_carrier
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(running_w && !dc_level_select_q),
    .use_sec(sec_next_w),
    .pri(pri_q),
    .sec(sec_q),
    .carrier_q(car_w),
    .period_end_q(car_end_w)
  );

  // ==========================================================
  // Modulator tick and space comparison
  assign tick_w = running_w && (fsk_mode_w ? car_end_w
    : (div_q == PRESCALE_LAST));
  assign next_cnt_w = cnt_q - 17'h00001;
  // Compare the value about to be entered, so zero space matches at once
  assign space_hit_w = next_cnt_w[16]
    && ((~next_cnt_w[15:0]) == spc_q);
  assign reload_w = tick_w && space_hit_w;
  assign start_w = !running_w && module_enable_q;
  assign load_w = start_w || (reload_w && module_enable_q);
  assign stop_w = reload_w && !module_enable_q;
  // Pair for the next carrier period; the carrier latches it one clock
  // before the reload tick, so predict the swap to keep bursts aligned
  assign sec_next_w = start_w ? 1'b0
    : sec_sel_q ^ (fsk_mode_w && module_enable_q && running_w
    && space_hit_w);

  // Prescaler only runs while the modulator is busy, saving toggles
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_q <= 3'h0;
    else if (!running_w)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // ==========================================================
  // Down counter, space register and period state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 17'h00000;
      spc_q <= MOD_VAL_RST;
      exsp_q <= 1'b0;
      sec_sel_q <= 1'b0;
    end
    else if (load_w)
    begin
      state_q <= ST_RUN;
      cnt_q <= {1'b0, mark_q};
      spc_q <= space_q;
      exsp_q <= extended_space_q;
      if (start_w)
        sec_sel_q <= 1'b0;
      else if (fsk_mode_w)
        sec_sel_q <= ~sec_sel_q;
    end
    else if (stop_w)
      state_q <= ST_IDLE;
    else if (tick_w)
      cnt_q <= next_cnt_w;
  end

  // ==========================================================
  // Gate and output stage
  assign gate_w = !cnt_q[16] && !exsp_q;
  assign mod_w = gate_w && (dc_level_select_q || car_w);
  assign pin_d = running_w ? mod_w : latch_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      infrared_output_pin_q <= 1'b0;
    else
      infrared_output_pin_q <= pin_d;
  end

  // ==========================================================
  // End-of-cycle flag: status read arms, data low byte access clears
  assign clr_w = armed_q && (bus_wr || bus_rd)
    && ((bus_addr == ADDR_MARK_LO) || (bus_addr == ADDR_SPACE_LO));
  // A set in the clearing cycle wins, so no period end is lost
  assign end_of_cycle_flag_d = load_w || (end_of_cycle_flag_q && !clr_w);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      end_of_cycle_flag_q <= 1'b0;
      armed_q <= 1'b0;
      eoc_irq_q <= 1'b0;
    end
    else
    begin
      end_of_cycle_flag_q <= end_of_cycle_flag_d;
      if (bus_rd && (bus_addr == ADDR_MSC))
        armed_q <= 1'b1;
      else if (clr_w)
        armed_q <= 1'b0;
      eoc_irq_q <= end_of_cycle_flag_d && eocie_q;
    end
  end

  // ==========================================================
  // Read mux; unmapped indices read zero
  always_comb
  begin
    msc_w = 8'h00;
    msc_w[MSC_EN_BIT] = module_enable_q;
    msc_w[MSC_DC_LEVEL_SELECT_BIT] = dc_level_select_q;
    msc_w[MSC_FSK_BIT] = fsk_q;
    msc_w[MSC_EXTENDED_SPACE_BIT] = extended_space_q;
    msc_w[MSC_EOCIE_BIT] = eocie_q;
    msc_w[MSC_END_OF_CYCLE_FLAG_BIT] = end_of_cycle_flag_q;
  end

  assign rd_mux_w =
    (bus_addr == ADDR_PRI_HI) ? pri_q.hi :
    (bus_addr == ADDR_PRI_LO) ? pri_q.lo :
    (bus_addr == ADDR_SEC_HI) ? sec_q.hi :
    (bus_addr == ADDR_SEC_LO) ? sec_q.lo :
    (bus_addr == ADDR_OUT_CTL) ? {7'h00, latch_q} :
    (bus_addr == ADDR_MSC) ? msc_w :
    (bus_addr == ADDR_MARK_HI) ? mark_q[15:8] :
    (bus_addr == ADDR_MARK_LO) ? mark_q[7:0] :
    (bus_addr == ADDR_SPACE_HI) ? space_q[15:8] :
    (bus_addr == ADDR_SPACE_LO) ? space_q[7:0] : 8'h00;

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_rdata_q <= 8'h00;
    else
      bus_rdata_q <= bus_rd ? rd_mux_w : 8'h00;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_period_end;
    running_w && reload_w;
  endsequence

  sequence s_mark_live;
    running_w && !cnt_q[16] && !exsp_q;
  endsequence

  a_reload_mark: assert property (s_period_end ##0 module_enable_q
    |=> cnt_q == {1'b0, $past(mark_q)} && spc_q == $past(space_q))
    else $error("period end did not reload counter and space");
  a_eoc_set: assert property (load_w |=> end_of_cycle_flag_q)
    else $error("end-of-cycle flag missed a load");
  a_fsk_swap: assert property (s_period_end ##0 module_enable_q
    && fsk_mode_w |=> sec_sel_q != $past(sec_sel_q))
    else $error("carrier pair not swapped at period end");
  a_stop_idle: assert property (s_period_end ##0 !module_enable_q
    |=> !running_w ##1 infrared_output_pin_q == $past(latch_q))
    else $error("modulator did not stop after last cycle");
  a_latch_follow: assert property (!running_w && !start_w
    |=> infrared_output_pin_q == $past(latch_q))
    else $error("idle pin does not follow output latch");
  a_dc_level_select_mark: assert property (s_mark_live ##0 dc_level_select_q
    |=> infrared_output_pin_q)
    else $error("baseband mark not at active level");
  a_exsp_quiet: assert property (running_w && exsp_q
    |=> !infrared_output_pin_q)
    else $error("extended space period produced a mark");
  a_tick_spacing: assert property (tick_w && !fsk_mode_w
    |=> !tick_w [*7])
    else $error("modulator tick closer than eight clocks");
  a_gate_closed: assert property (running_w && cnt_q[16]
    && !dc_level_select_q |=> !infrared_output_pin_q)
    else $error("gate open while counter negative");
  a_no_run_off: assert property (!module_enable_q && !running_w
    |=> !running_w)
    else $error("modulator started while disabled");

endmodule // icm_top

`default_nettype wire

// [verif/icm_emitter.sv]
/*
  Emitter model: watches the infrared pin and times each high and low run.
  Assumes the pin is a registered level on clk and active high.
*/
`timescale 1ns/100ps
`default_nettype none

module icm_emitter
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic [16:0] hi_len,
  output logic [16:0] lo_len,
  output logic hi_done,
  output logic lo_done
);
  logic [16:0] run_q;
  logic pin_q;

  // ====================
  // Run timer
  // A run closes on the edge where the level flips; the first is partial
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_q <= 17'h00000;
      pin_q <= 1'b0;
      hi_len <= 17'h00000;
      lo_len <= 17'h00000;
      hi_done <= 1'b0;
      lo_done <= 1'b0;
    end
    else
    begin
      pin_q <= pin;
      hi_done <= (pin != pin_q) && pin_q;
      lo_done <= (pin != pin_q) && !pin_q;
      if (pin != pin_q)
      begin
        run_q <= 17'h00001;
        if (pin_q)
          hi_len <= run_q;
        else
          lo_len <= run_q;
      end
      else
        run_q <= run_q + 17'h00001;
    end
  end
endmodule // icm_emitter

`default_nettype wire

// [verif/icm_top_tb.sv]
/*
  Self-checking bench of the carrier modulator: register reset values,
  latch pin, time, baseband, extended space, disable and FSK timing.
  Assumes the emitter model times the pin runs.
*/
`timescale 1ns/100ps
`default_nettype none

module icm_top_tb;
  import icm_pkg::*;
  logic clk;
  logic sys_rst;
  icm_addr_t bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata_q;
  logic eoc_irq_q;
  logic pin;
  logic [16:0] hi_len;
  logic [16:0] lo_len;
  logic hi_done;
  logic lo_done;
  int errors;
  int tests_run;
  int i0;
  logic [7:0] rv;
  logic [16:0] n, m, s, h, h2, l, mk, sp, per;
  logic [16:0] runs [13];

  icm_top dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_q(bus_rdata_q), .eoc_irq_q(eoc_irq_q),
    .infrared_output_pin_q(pin));
  icm_emitter em (.clk(clk), .sys_rst(sys_rst), .pin(pin),
    .hi_len(hi_len), .lo_len(lo_len), .hi_done(hi_done),
    .lo_done(lo_done));

  // ====================
  // Clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ====================
  // Verdict and comparison
  task end_of_test;
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input string what, input logic [16:0] seen,
    input logic [16:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // ====================
  // Register port: one-cycle strobes, read data one cycle later
  task wr(input icm_addr_t a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task rd(input icm_addr_t a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata_q;
  endtask

  // Bounded wait for the end of a high or low run at the pin
  task bwait(input logic want_hi, output logic [16:0] len);
    int i;
    for (i = 0; i < 20000; i++)
    begin
      @(negedge clk);
      if (want_hi ? hi_done : lo_done)
        break;
    end
    if (i == 20000)
    begin
      errors++;
      end_of_test;
    end
    else
      len = want_hi ? hi_len : lo_len;
  endtask

  task reset_dut;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // ====================
  // Main sequence
  initial
  begin
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    sys_rst = 1'b1;
    errors = 0;
    tests_run = 0;
    rv = 8'($urandom(47253));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, then an unmapped index that must read zero
    for (int a = 0; a < 11; a++)
    begin
      rd((a == 10) ? 4'hF : 4'(a), rv);
      check("reset value", {9'h000, rv}, (a < 4) ? 17'h00001 : 17'h00000);
    end
    wr(ADDR_OUT_CTL, 8'h01);
    repeat (2) @(posedge clk);
    check("latch pin", {16'h0000, pin}, 17'h00001);
    wr(ADDR_OUT_CTL, 8'h00);
    // Time mode with a long mark: carrier runs through an open gate
    h = 17'($urandom_range(6, 1));
    l = 17'($urandom_range(6, 1));
    wr(ADDR_PRI_HI, h[7:0]);
    wr(ADDR_PRI_LO, l[7:0]);
    wr(ADDR_MARK_LO, 8'h10);
    wr(ADDR_SPACE_LO, 8'h02);
    wr(ADDR_MSC, 8'h01);
    rd(ADDR_MSC, rv);
    check("start flag", {16'h0000, rv[MSC_END_OF_CYCLE_FLAG_BIT]}, 17'h00001);
    bwait(1'b1, n);
    repeat (3)
    begin
      bwait(1'b0, n);
      check("carrier low", n, l);
      bwait(1'b1, n);
      check("carrier high", n, h);
    end
    // Let the gate close through one time-mode space
    repeat (160) @(posedge clk);
    // Baseband: mark and space in divided clock ticks
    reset_dut;
    m = 17'($urandom_range(6, 1));
    s = 17'($urandom_range(5, 1));
    mk = (m + 17'h00001) << 3;
    sp = s << 3;
    per = mk + sp;
    wr(ADDR_MARK_LO, m[7:0]);
    wr(ADDR_SPACE_LO, s[7:0]);
    wr(ADDR_MSC, 8'h13);
    repeat (2) @(posedge clk);
    check("irq set", {16'h0000, eoc_irq_q}, 17'h00001);
    rd(ADDR_MSC, rv);
    rd(ADDR_MARK_LO, rv);
    repeat (2) @(posedge clk);
    check("irq cleared", {16'h0000, eoc_irq_q}, 17'h00000);
    bwait(1'b1, n);
    bwait(1'b0, n);
    check("space", n, sp);
    bwait(1'b1, n);
    check("mark", n, mk);
    // Extended space held for a few periods, then cleared
    wr(ADDR_MSC, 8'h1B);
    repeat (3 * per) @(posedge clk);
    wr(ADDR_MSC, 8'h13);
    bwait(1'b0, n);
    check("ext space", (n >= sp + per) ? (n - sp) % per : 17'h1FFFF,
      17'h00000);
    bwait(1'b1, n);
    check("resumed mark", n, mk);
    // Disable during a mark: the period finishes, then the pin rests
    bwait(1'b0, n);
    // Baseband kept: mode bits must not change while running
    wr(ADDR_MSC, 8'h02);
    bwait(1'b1, n);
    check("last mark", n, mk);
    repeat (2 * per) @(posedge clk);
    check("stopped pin", {16'h0000, pin}, 17'h00000);
    // FSK with zero space: bursts of three carrier periods per pair
    reset_dut;
    h = 17'($urandom_range(4, 1));
    h2 = h + 17'($urandom_range(3, 1));
    l = 17'($urandom_range(4, 1));
    wr(ADDR_PRI_HI, h[7:0]);
    wr(ADDR_PRI_LO, l[7:0]);
    wr(ADDR_SEC_HI, h2[7:0]);
    wr(ADDR_SEC_LO, l[7:0]);
    wr(ADDR_MARK_LO, 8'h02);
    wr(ADDR_MSC, 8'h05);
    for (int i = 0; i < 13; i++)
      bwait(1'b1, runs[i]);
    check("primary burst", runs[1], h);
    check("primary burst", runs[2], h);
    i0 = 3;
    for (int k = 0; k < 9; k++)
      check("fsk burst", runs[i0 + k], ((k / 3) % 2 == 0) ? h2 : h);
    end_of_test;
  end
endmodule // icm_top_tb

`default_nettype wire
